// [include/cld_pkg.sv]
package cld_pkg;
   // quadrant codes
   localparam logic [1:0] QUAD_REG = 2'h0;
   localparam logic [1:0] QUAD_STACK = 2'h2;
   // function codes
   localparam logic [2:0] FN_WORD = 3'h2;
   localparam logic [2:0] FN_DWORD = 3'h3;
   localparam logic [2:0] FN_CAP64 = 3'h1;
   // violation codes for the trap_field_a field
   localparam logic [4:0] TRAP_FIELD_A_NONE = 5'h00;
   localparam logic [4:0] TRAP_FIELD_A_TAG = 5'h02;
   localparam logic [4:0] TRAP_FIELD_A_SEAL = 5'h03;
   localparam logic [4:0] TRAP_FIELD_A_PERM = 5'h12;
   localparam logic [4:0] TRAP_FIELD_A_LEN = 5'h01;
   // data-fault type code for the trap value type field
   localparam logic [3:0] TYPE_DATA = 4'h0;
   // stack pointer register index
   localparam logic [4:0] REG_SP = 5'h02;
   // load kinds, one-hot
   typedef enum logic [7:0] {
      K_NONE = 8'h01,
      K_WORD = 8'h02,
      K_DWORD = 8'h04,
      K_SFLOAT = 8'h08,
      K_DFLOAT = 8'h10,
      K_CAP = 8'h20,
      K_ILLEGAL = 8'h40
   } load_kind_e;
   // decoded load operation
   typedef struct packed {
      load_kind_e kind;
      logic stack_rel;
      logic [4:0] base;
      logic [4:0] dest;
      logic [9:0] offset;
      logic use_default_cap;
      logic [4:0] size_bytes;
   } load_op_s;
   // authorising capability view
   typedef struct packed {
      logic tag;
      logic sealed;
      logic perm_read;
      logic [63:0] base;
      logic [64:0] top;
   } cap_s;
   // fault report
   typedef struct packed {
      logic cap_fault;
      logic misaligned;
      logic illegal;
      logic [3:0] fault_type;
      logic [4:0] trap_field_a;
   } fault_s;
endpackage

// [verilog/cld_decoder.sv]
`timescale 1ns/1ps
module cld_decoder
   import cld_pkg::*;
#(
   parameter int XLEN64 = 1,
   parameter int HAS_F = 1,
   parameter int HAS_D = 1,
   parameter int HAS_PURECAP = 1,
   parameter int HAS_LEGACY = 1
) (
   input wire logic [15:0] i_insn,
   input wire logic i_cap_mode,
   output load_op_s o_op
);
   // expand 3-bit compact register to full index
   function automatic logic [4:0] compact_reg(input logic [2:0] r);
      compact_reg = {2'h1, r};
   endfunction

   // combinational decode of one 16-bit load
   always_comb begin
      logic [2:0] fn;
      logic [1:0] quad;
      logic modeok;
      fn = i_insn[15:13];
      quad = i_insn[1:0];
      modeok = i_cap_mode ? (HAS_PURECAP != 0) : (HAS_LEGACY != 0);
      o_op = '0;
      o_op.kind = K_NONE;
      o_op.use_default_cap = !i_cap_mode;
      if (quad == QUAD_REG && modeok) begin
         o_op.base = compact_reg(i_insn[9:7]);
         o_op.dest = compact_reg(i_insn[4:2]);
         if (fn == FN_WORD) begin
            o_op.kind = K_WORD;
            o_op.size_bytes = 5'h04;
            o_op.offset = {3'h0, i_insn[5], i_insn[12:10], i_insn[6], 2'h0};
         end else if (fn == FN_DWORD && i_cap_mode && XLEN64 == 0) begin
            o_op.kind = K_CAP;
            o_op.size_bytes = 5'h08;
            o_op.offset = {2'h0, i_insn[6:5], i_insn[12:10], 3'h0};
         end else if (fn == FN_DWORD && XLEN64 != 0) begin
            o_op.kind = K_DWORD;
            o_op.size_bytes = 5'h08;
            o_op.offset = {2'h0, i_insn[6:5], i_insn[12:10], 3'h0};
         end else if (fn == FN_DWORD && HAS_F != 0) begin
            o_op.kind = K_SFLOAT;
            o_op.size_bytes = 5'h04;
            o_op.offset = {3'h0, i_insn[5], i_insn[12:10], i_insn[6], 2'h0};
         end else if (fn == FN_CAP64 && XLEN64 != 0) begin
            o_op.kind = i_cap_mode ? K_CAP : (HAS_D != 0 ? K_DFLOAT : K_NONE);
            o_op.size_bytes = i_cap_mode ? 5'h10 : 5'h08;
            o_op.offset = i_cap_mode ?
               {1'b0, i_insn[10], i_insn[6:5], i_insn[12:11], 4'h0} :
               {2'h0, i_insn[6:5], i_insn[12:10], 3'h0};
         end
      end else if (quad == QUAD_STACK && modeok) begin
         o_op.stack_rel = 1'b1;
         o_op.base = REG_SP;
         o_op.dest = i_insn[11:7];
         if (fn == FN_WORD) begin
            o_op.kind = K_WORD;
            o_op.size_bytes = 5'h04;
            o_op.offset = {2'h0, i_insn[3:2], i_insn[12], i_insn[6:4], 2'h0};
         end else if (fn == FN_DWORD && i_cap_mode && XLEN64 == 0) begin
            o_op.kind = K_CAP;
            o_op.size_bytes = 5'h08;
            o_op.offset = {1'b0, i_insn[4:2], i_insn[12], i_insn[6:5], 3'h0};
         end else if (fn == FN_DWORD && XLEN64 != 0) begin
            o_op.kind = K_DWORD;
            o_op.size_bytes = 5'h08;
            o_op.offset = {1'b0, i_insn[4:2], i_insn[12], i_insn[6:5], 3'h0};
         end else if (fn == FN_DWORD && HAS_F != 0) begin
            o_op.kind = K_SFLOAT;
            o_op.size_bytes = 5'h04;
            o_op.offset = {2'h0, i_insn[3:2], i_insn[12], i_insn[6:4], 2'h0};
         end else if (fn == FN_CAP64 && XLEN64 != 0) begin
            // stack cap load or double float
            o_op.kind = i_cap_mode ? K_CAP : (HAS_D != 0 ? K_DFLOAT : K_NONE);
            o_op.size_bytes = i_cap_mode ? 5'h10 : 5'h08;
            o_op.offset = i_cap_mode ?
               {i_insn[5:2], i_insn[12], i_insn[6], 4'h0} :
               {1'b0, i_insn[4:2], i_insn[12], i_insn[6:5], 3'h0};
         end
         if ((o_op.kind == K_WORD || o_op.kind == K_DWORD ||
              o_op.kind == K_CAP) && o_op.dest == 5'h00) begin
            o_op.kind = K_ILLEGAL;
         end
      end
   end
endmodule // cld_decoder

// [verilog/cld_auth_check.sv]
`timescale 1ns/1ps
module cld_auth_check
   import cld_pkg::*;
(
   input wire cap_s i_auth,
   input wire logic [63:0] i_addr,
   input wire logic [4:0] i_size,
   input wire logic i_is_cap,
   output fault_s o_fault
);
   // priority checks: tag, seal, permission, length, alignment
   always_comb begin
      logic [64:0] last;
      last = {1'b0, i_addr} + {60'h0, i_size};
      o_fault = '0;
      o_fault.fault_type = TYPE_DATA;
      o_fault.trap_field_a = TRAP_FIELD_A_NONE;
      if (!i_auth.tag) begin
         o_fault.cap_fault = 1'b1;
         o_fault.trap_field_a = TRAP_FIELD_A_TAG;
      end else if (i_auth.sealed) begin
         o_fault.cap_fault = 1'b1;
         o_fault.trap_field_a = TRAP_FIELD_A_SEAL;
      end else if (!i_auth.perm_read) begin
         o_fault.cap_fault = 1'b1;
         o_fault.trap_field_a = TRAP_FIELD_A_PERM;
      end else if (i_addr < i_auth.base || last > i_auth.top) begin
         o_fault.cap_fault = 1'b1;
         o_fault.trap_field_a = TRAP_FIELD_A_LEN;
      end else if (i_is_cap &&
                   (i_addr[3:0] & (i_size[3:0] - 4'h1)) != 4'h0) begin
         o_fault.misaligned = 1'b1;
      end
   end
endmodule // cld_auth_check

// [verilog/compressed_load_decode_check.sv]
`timescale 1ns/1ps
module compressed_load_decode_check
   import cld_pkg::*;
#(
   parameter int XLEN64 = 1,
   parameter int HAS_F = 1,
   parameter int HAS_D = 1,
   parameter int HAS_PURECAP = 1,
   parameter int HAS_LEGACY = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [15:0] i_insn,
   input wire logic i_cap_mode,
   input wire cap_s i_base_cap,
   input wire cap_s i_stack_cap,
   input wire cap_s i_default_cap,
   input wire logic [63:0] i_base_int,
   input wire logic [63:0] i_sp_int,
   input wire logic i_ready,
   output logic o_ready,
   output logic o_valid,
   output load_op_s o_op,
   output logic [63:0] o_addr,
   output fault_s o_fault
);
   // decoded operation
   load_op_s dec_op;
   // chosen authority and address
   cap_s auth;
   logic [63:0] addr;
   // check result
   fault_s chk;
   // final fault word
   fault_s next_fault;

   // instruction decode
   cld_decoder #(
      .XLEN64(XLEN64),
      .HAS_F(HAS_F),
      .HAS_D(HAS_D),
      .HAS_PURECAP(HAS_PURECAP),
      .HAS_LEGACY(HAS_LEGACY)
   ) u_dec (
      .i_insn(i_insn),
      .i_cap_mode(i_cap_mode),
      .o_op(dec_op)
   );

   // authority and address selection
   always_comb begin
      if (dec_op.stack_rel) begin
         auth = i_cap_mode ? i_stack_cap : i_default_cap;
         addr = (i_cap_mode ? i_stack_cap.base : 64'h0) + i_sp_int
                + {54'h0, dec_op.offset};
      end else begin
         auth = i_cap_mode ? i_base_cap : i_default_cap;
         addr = i_base_int + {54'h0, dec_op.offset};
      end
   end

   // authority checks
   cld_auth_check u_chk (
      .i_auth(auth),
      .i_addr(addr),
      .i_size(dec_op.size_bytes),
      .i_is_cap(dec_op.kind == K_CAP),
      .o_fault(chk)
   );

   // combine illegal decode with checks
   always_comb begin
      next_fault = '0;
      next_fault.fault_type = TYPE_DATA;
      next_fault.trap_field_a = TRAP_FIELD_A_NONE;
      case (dec_op.kind)
         K_ILLEGAL: begin
            next_fault.illegal = 1'b1;
         end
         K_NONE: begin
            // not a load: nothing to report
            next_fault.illegal = 1'b0;
         end
         default: begin
            next_fault = chk;
         end
      endcase
   end

   // stalls when the pipeline refuses
   assign o_ready = !o_valid || i_ready;

   // output valid
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
      end else if (o_ready) begin
         o_valid <= i_valid && dec_op.kind != K_NONE;
      end
   end

   // output data register, holds the decoded load until taken
   // expanded load passed on
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_op <= '0;
         o_addr <= 64'h0;
         o_fault <= '0;
      end else if (o_ready && i_valid) begin
         o_op <= dec_op;
         o_addr <= addr;
         o_fault <= next_fault;
      end
   end
endmodule // compressed_load_decode_check

// [testbench/cld_props.sv]
`timescale 1ns/1ps
module cld_props
   import cld_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [15:0] i_insn,
   input wire logic i_cap_mode,
   input wire logic i_ready,
   input wire logic o_ready,
   input wire logic o_valid,
   input wire load_op_s o_op,
   input wire fault_s o_fault
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // a request is taken at this edge
   sequence s_take;
      i_valid && o_ready;
   endsequence
   // register-form word load taken
   sequence s_reg_word;
      s_take ##0 (i_insn[1:0] == QUAD_REG && i_insn[15:13] == FN_WORD);
   endsequence
   // stack-form load with the given code taken
   sequence s_stack(logic [2:0] fn);
      s_take ##0 (i_insn[1:0] == QUAD_STACK && i_insn[15:13] == fn);
   endsequence
   chk_ready_flow: assert property (
      o_valid && i_ready && !i_valid |=> !o_valid) else $error("ready flow");
   chk_hold_stall: assert property (
      o_valid && !i_ready |=> o_valid && $stable(o_op) && $stable(o_fault))
      else $error("output not held");
   chk_word_reg: assert property (
      s_reg_word |=> o_valid && o_op.kind == K_WORD
      && o_op.size_bytes == 5'h04) else $error("word decode");
   chk_reg_offset: assert property (
      s_reg_word |=> o_op.offset == {3'h0, $past(i_insn[5]),
      $past(i_insn[12:10]), $past(i_insn[6]), 2'h0}) else $error("offset");
   chk_auth_select: assert property (
      s_reg_word |=> o_op.use_default_cap == !$past(i_cap_mode))
      else $error("authority choice");
   chk_stack_dword: assert property (
      s_stack(FN_DWORD) ##0 i_insn[11:7] != 5'h00
      |=> o_op.kind == K_DWORD && o_op.stack_rel) else $error("dword");
   chk_zero_dest: assert property (
      s_stack(FN_WORD) ##0 i_insn[11:7] == 5'h00
      |=> o_fault.illegal && o_op.kind == K_ILLEGAL) else $error("zero dest");
   chk_cap_stack: assert property (
      s_stack(FN_CAP64) ##0 (i_cap_mode && i_insn[11:7] != 5'h00)
      |=> o_op.kind == K_CAP) else $error("cap load");
   chk_fault_type: assert property (
      o_valid && o_fault.cap_fault |-> o_fault.fault_type == TYPE_DATA
      && o_fault.trap_field_a != TRAP_FIELD_A_NONE) else $error("fault type");
endmodule // cld_props
bind compressed_load_decode_check cld_props i_chk (.i_clk, .i_rst_n,
   .i_valid, .i_insn, .i_cap_mode, .i_ready, .o_ready, .o_valid, .o_op,
   .o_fault);

// [testbench/cld_sink.sv]
`timescale 1ns/1ps
module cld_sink (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_stall,
   output logic o_ready
);
   // ready trails the stall request by a cycle, like a real pipe stage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= !i_stall;
      end
   end
endmodule // cld_sink

// [testbench/compressed_load_decode_check_tb.sv]
`timescale 1ns/1ps
module compressed_load_decode_check_tb;
   import cld_pkg::*;
   logic clk, rst_n, valid, cap_mode, ready, o_ready, o_valid, stall;
   logic [15:0] insn;
   logic [63:0] base_int, sp_int, addr;
   cap_s base_cap, stack_cap, default_cap;
   load_op_s op;
   fault_s fault;
   int mismatches, compares;
   localparam logic [64:0] TOP = 65'h1_0000_0000;
   `define CHK(g, e) check(64'(g), 64'(e))
   compressed_load_decode_check i_dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_valid(valid), .i_insn(insn), .i_cap_mode(cap_mode),
      .i_base_cap(base_cap), .i_stack_cap(stack_cap),
      .i_default_cap(default_cap), .i_base_int(base_int), .i_sp_int(sp_int),
      .i_ready(ready), .o_ready(o_ready), .o_valid(o_valid), .o_op(op),
      .o_addr(addr), .o_fault(fault));
   cld_sink i_sink (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
      .o_ready(ready));
   // capability with flags {tag, sealed, read} and base zero
   function automatic cap_s cap(logic [2:0] f, logic [64:0] t);
      return '{f[2], f[1], f[0], 64'h0, t};
   endfunction
   function automatic load_op_s mk(load_kind_e k, logic s, logic [4:0] b,
      logic [4:0] d, logic [9:0] o, logic c, logic [4:0] z);
      return '{k, s, b, d, o, c, z};
   endfunction
   task automatic check(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // present one request at an edge, sample the answer at the negedge after the edge that takes it
   task automatic issue(input logic [15:0] ins, input logic cm);
      int n;
      n = 0;
      valid <= 1'b1;
      insn <= ins;
      cap_mode <= cm;
      do begin
         @(negedge clk);
         n++;
      end while (o_ready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      @(posedge clk);
      valid <= 1'b0;
      @(negedge clk);
   endtask
   task automatic t_reg_word;
      @(posedge clk);
      base_int <= 64'h1000;
      issue(16'h54C8, 1'b0);
      `CHK(op, mk(K_WORD,1'b0,5'h09,5'h0A,10'h02C,1'b1,5'h04));
      `CHK(addr, 64'h102C);
      @(posedge clk);
      base_cap <= cap(3'h1, TOP);
      issue(16'h54C8, 1'b1);
      `CHK({op.use_default_cap, fault.cap_fault, fault.trap_field_a}, 7'h22);
      `CHK(fault.fault_type, TYPE_DATA);
      $display("t_reg_word done");
   endtask
   task automatic t_faults;
      cap_s c [6];
      logic [4:0] e [6];
      c = '{cap(3'h1, 65'h2000), cap(3'h7, 65'h2000), cap(3'h4, 65'h2000),
         cap(3'h5, 65'h102F), cap(3'h5, 65'h1030), cap(3'h2, 65'h102F)};
      e = '{TRAP_FIELD_A_TAG, TRAP_FIELD_A_SEAL, TRAP_FIELD_A_PERM, TRAP_FIELD_A_LEN, TRAP_FIELD_A_NONE,
         TRAP_FIELD_A_TAG};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         default_cap <= c[i];
         issue(16'h54C8, 1'b0);
         `CHK({fault.cap_fault, fault.trap_field_a}, {e[i] != 5'h00, e[i]});
      end
      $display("t_faults done");
   endtask
   task automatic t_stack;
      load_op_s x [2];
      x[0] = mk(K_WORD, 1'b1, REG_SP, 5'h03, 10'h074, 1'b1, 5'h04);
      x[1] = mk(K_DWORD, 1'b1, REG_SP, 5'h0A, 10'h078, 1'b1, 5'h08);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         default_cap <= cap(3'h5, TOP);
         sp_int <= 64'h0100;
         issue(i ? 16'h7566 : 16'h51D6, 1'b0);
         `CHK(op, x[i]);
         `CHK(addr, 64'h0100 + 64'(x[i].offset));
      end
      @(posedge clk);
      issue(16'h5056, 1'b0);
      `CHK({op.kind, fault.illegal}, {K_ILLEGAL, 1'b1});
      $display("t_stack done");
   endtask
   task automatic t_cap;
      load_op_s x;
      logic [63:0] a;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         base_cap <= cap(3'h5, TOP);
         sp_int <= (i == 1) ? 64'h1008 : 64'h1000;
         issue((i == 2) ? 16'h34A8 : 16'h354E, 1'b1);
         x = (i == 2) ? mk(K_CAP,1'b0,5'h09,5'h0A,10'h160,1'b0,5'h10)
            : mk(K_CAP,1'b1,REG_SP,5'h0A,10'h0F0,1'b0,5'h10);
         `CHK(op, x);
         a = ((i == 1) ? 64'h1008 : 64'h1000) + 64'(x.offset);
         `CHK(addr, a);
         `CHK({fault.misaligned, fault.cap_fault}, {i == 1, 1'b0});
      end
      @(posedge clk);
      issue(16'h354E, 1'b0);
      `CHK({op.kind, op.use_default_cap}, {K_DFLOAT, 1'b1});
      $display("t_cap done");
   endtask
   // far side stalls; a second request waits refused, then goes through
   task automatic t_stall;
      @(posedge clk);
      stall <= 1'b1;
      @(posedge clk);
      issue(16'h54C8, 1'b0);
      @(posedge clk);
      valid <= 1'b1;
      insn <= 16'h7566;
      repeat (3) begin
         @(negedge clk);
         `CHK({o_valid, o_ready, op.offset}, {2'h2, 10'h02C});
      end
      @(posedge clk);
      stall <= 1'b0;
      issue(16'h7566, 1'b0);
      `CHK(op.offset, 10'h078);
      @(posedge clk);
      issue(16'h0001, 1'b0);
      `CHK(o_valid, 1'b0);
      $display("t_stall done");
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // tests need under a hundred cycles; cut off at about four thousand
   initial begin
      #100000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      {rst_n, valid, cap_mode, stall, insn, base_int, sp_int} = '0;
      base_cap = cap(3'h5, TOP);
      stack_cap = cap(3'h5, TOP);
      default_cap = cap(3'h5, TOP);
      mismatches = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      `CHK({o_valid, o_ready}, 2'h1);
      rst_n <= 1'b1;
      t_reg_word();
      t_faults();
      t_stack();
      t_cap();
      t_stall();
      report_and_stop();
   end
endmodule // compressed_load_decode_check_tb
